// [rx_config_register_bank.v]
// receiver configuration register bank with control outputs
`timescale 1ns/1ns
`include "rx_cfg_consts.vh"

module rx_config_register_bank #(
  parameter ADDR_W = 6
) (
  // clock and reset
  input  wire              CLK_I,
  input  wire              RST_N_I,
  // host register port
  input  wire [ADDR_W-1:0] ADDR_I,
  input  wire              WR_EN_I,
  input  wire              RD_EN_I,
  input  wire [7:0]        WDATA_I,
  output reg  [7:0]        RDATA_O,
  output reg               RVALID_O,
  // direct commands
  input  wire              SET_DEFAULT_I,
  input  wire              RESET_RX_GAIN_I,
  // receiver events
  input  wire              TX_END_I,
  input  wire              MASK_EXPIRED_I,
  input  wire              SINGLE_ENDED_I,
  // filter and channel controls
  output reg               RX_CHANNEL_PICK_O,
  output reg               AM_DEMOD_MIXER_O,
  output reg  [2:0]        LOWPASS_CODE_O,
  output reg  [2:0]        ZERO_SET_O,
  // agc and squelch controls
  output reg               RECEIVER_LOW_POWER_O,
  output reg               LOWFREQ_SPLIT_ROUTE_O,
  output reg               LOWFREQ_INPUT_ON_O,
  output reg               AGC_ENABLE_O,
  output reg               AGC_FULL_PERIOD_O,
  output reg               AGC_RESET_ALG_O,
  output reg               SQUELCH_ACTIVE_O,
  output reg               PM_MIXER_CLOCK_SRC_O,
  // gain controls
  output reg  [2:0]        AM_FIRST_STAGE_GAIN_O,
  output reg  [2:0]        PM_FIRST_STAGE_GAIN_O,
  output reg               STAGE_CLIP_O,
  output reg               PEER_MODE_GAIN_FORCE_O,
  output reg  [3:0]        AM_LATER_STAGE_GAIN_O,
  output reg  [3:0]        PM_LATER_STAGE_GAIN_O
);

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam SQUELCH_CYC = (`SQUELCH_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // register defaults, sliced for the output flops
  // ----------------------------------------------------------------
  localparam [7:0] DFLT_FILTER = `RST_FILTER_CHANNEL;
  localparam [7:0] DFLT_AGC    = `RST_AGC_SQUELCH;
  localparam [7:0] DFLT_FIRST  = `RST_FIRST_GAIN;
  localparam [7:0] DFLT_LATER  = `RST_LATER_GAIN;

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  reg  [2:0] sync1_r;
  reg  [2:0] sync2_r;
  reg        tx_end_d_r;
  reg        mask_d_r;
  wire       tx_end_pulse;
  wire       mask_pulse;
  wire       single_ended;

  always @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      sync1_r    <= 3'h0;
      sync2_r    <= 3'h0;
      tx_end_d_r <= 1'b0;
      mask_d_r   <= 1'b0;
    end else begin
      sync1_r    <= {SINGLE_ENDED_I, MASK_EXPIRED_I, TX_END_I};
      sync2_r    <= sync1_r;
      tx_end_d_r <= sync2_r[0];
      mask_d_r   <= sync2_r[1];
    end
  end

  assign tx_end_pulse = sync2_r[0] & ~tx_end_d_r;
  assign mask_pulse   = sync2_r[1] & ~mask_d_r;
  assign single_ended = sync2_r[2];

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg  [7:0] filter_channel_r;
  reg  [7:0] agc_squelch_r;
  reg  [7:0] first_gain_r;
  reg  [7:0] later_gain_r;
  reg  [7:0] later_loaded_r;
  wire       hit_filter;
  wire       hit_agc;
  wire       hit_first;
  wire       hit_later;

  assign hit_filter = WR_EN_I && (ADDR_I == `ADDR_FILTER_CHANNEL);
  assign hit_agc    = WR_EN_I && (ADDR_I == `ADDR_AGC_SQUELCH);
  assign hit_first  = WR_EN_I && (ADDR_I == `ADDR_FIRST_GAIN);
  assign hit_later  = WR_EN_I && (ADDR_I == `ADDR_LATER_GAIN);

  always @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      filter_channel_r <= `RST_FILTER_CHANNEL;
      agc_squelch_r    <= `RST_AGC_SQUELCH;
      first_gain_r     <= `RST_FIRST_GAIN;
      later_gain_r     <= `RST_LATER_GAIN;
      later_loaded_r   <= `RST_LATER_GAIN;
    end else if (SET_DEFAULT_I) begin
      filter_channel_r <= `RST_FILTER_CHANNEL;
      agc_squelch_r    <= `RST_AGC_SQUELCH;
      first_gain_r     <= `RST_FIRST_GAIN;
      later_gain_r     <= `RST_LATER_GAIN;
      later_loaded_r   <= `RST_LATER_GAIN;
    end else begin
      if (hit_filter) begin
        filter_channel_r <= WDATA_I;
      end
      if (hit_agc) begin
        agc_squelch_r <= WDATA_I;
      end
      if (hit_first) begin
        first_gain_r <= WDATA_I;
      end
      if (hit_later) begin
        later_gain_r <= WDATA_I;
      end
      if (RESET_RX_GAIN_I) begin
        later_loaded_r <= later_gain_r;
      end
    end
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  always @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      RDATA_O  <= 8'h00;
      RVALID_O <= 1'b0;
    end else begin
      RVALID_O <= RD_EN_I;
      if (!RD_EN_I) begin
        RDATA_O <= 8'h00;
      end else if (ADDR_I == `ADDR_FILTER_CHANNEL) begin
        RDATA_O <= filter_channel_r;
      end else if (ADDR_I == `ADDR_AGC_SQUELCH) begin
        RDATA_O <= agc_squelch_r;
      end else if (ADDR_I == `ADDR_FIRST_GAIN) begin
        RDATA_O <= first_gain_r;
      end else if (ADDR_I == `ADDR_LATER_GAIN) begin
        RDATA_O <= later_gain_r;
      end else begin
        RDATA_O <= 8'h00;
      end
    end
  end

  // ----------------------------------------------------------------
  // automatic squelch
  // ----------------------------------------------------------------
  wire squelch;

  rx_squelch_timer #(
    .DELAY_CYC (SQUELCH_CYC)
  ) u_squelch (
    .clk_i          (CLK_I),
    .rst_n_i        (RST_N_I),
    .enable_i       (agc_squelch_r[`B_SQUELCH_AUTO]),
    .tx_end_i       (tx_end_pulse),
    .mask_expired_i (mask_pulse),
    .squelch_o      (squelch)
  );

  // ----------------------------------------------------------------
  // control outputs
  // ----------------------------------------------------------------
  always @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      // register-field outputs show the register defaults while reset is held; SQUELCH_ACTIVE_O is held low
      RX_CHANNEL_PICK_O      <= DFLT_FILTER[`B_CH_PICK];
      AM_DEMOD_MIXER_O       <= DFLT_FILTER[`B_AMD_MIXER];
      LOWPASS_CODE_O         <= DFLT_FILTER[`F_LOWPASS];
      ZERO_SET_O             <= DFLT_FILTER[`F_ZERO_SET];
      RECEIVER_LOW_POWER_O   <= DFLT_AGC[`B_LOW_POWER];
      LOWFREQ_SPLIT_ROUTE_O  <= DFLT_AGC[`B_LF_SPLIT];
      LOWFREQ_INPUT_ON_O     <= DFLT_AGC[`B_LF_ON];
      AGC_ENABLE_O           <= DFLT_AGC[`B_AGC_EN];
      AGC_FULL_PERIOD_O      <= DFLT_AGC[`B_AGC_FULL];
      AGC_RESET_ALG_O        <= DFLT_AGC[`B_AGC_RESET_ALG];
      SQUELCH_ACTIVE_O       <= 1'b0;
      PM_MIXER_CLOCK_SRC_O   <= DFLT_AGC[`B_PMIX_INTERNAL];
      AM_FIRST_STAGE_GAIN_O  <= DFLT_FIRST[`F_AM_FIRST];
      PM_FIRST_STAGE_GAIN_O  <= DFLT_FIRST[`F_PM_FIRST];
      STAGE_CLIP_O           <= DFLT_FIRST[`B_CLIP];
      PEER_MODE_GAIN_FORCE_O <= DFLT_FIRST[`B_PEER_FORCE];
      AM_LATER_STAGE_GAIN_O  <= DFLT_LATER[`F_AM_LATER];
      PM_LATER_STAGE_GAIN_O  <= DFLT_LATER[`F_PM_LATER];
    end else begin
      RX_CHANNEL_PICK_O      <= filter_channel_r[`B_CH_PICK];
      AM_DEMOD_MIXER_O       <= filter_channel_r[`B_AMD_MIXER];
      LOWPASS_CODE_O         <= filter_channel_r[`F_LOWPASS];
      ZERO_SET_O             <= filter_channel_r[`F_ZERO_SET];
      RECEIVER_LOW_POWER_O   <= agc_squelch_r[`B_LOW_POWER];
      LOWFREQ_SPLIT_ROUTE_O  <= agc_squelch_r[`B_LF_SPLIT];
      LOWFREQ_INPUT_ON_O     <= agc_squelch_r[`B_LF_ON];
      AGC_ENABLE_O           <= agc_squelch_r[`B_AGC_EN];
      AGC_FULL_PERIOD_O      <= agc_squelch_r[`B_AGC_FULL];
      AGC_RESET_ALG_O        <= agc_squelch_r[`B_AGC_RESET_ALG];
      SQUELCH_ACTIVE_O       <= squelch;
      // single-ended operation always uses the internal mixer clock
      PM_MIXER_CLOCK_SRC_O   <= agc_squelch_r[`B_PMIX_INTERNAL] | single_ended;
      AM_FIRST_STAGE_GAIN_O  <= first_gain_r[`F_AM_FIRST];
      PM_FIRST_STAGE_GAIN_O  <= first_gain_r[`F_PM_FIRST];
      STAGE_CLIP_O           <= first_gain_r[`B_CLIP];
      PEER_MODE_GAIN_FORCE_O <= first_gain_r[`B_PEER_FORCE];
      AM_LATER_STAGE_GAIN_O  <= later_loaded_r[`F_AM_LATER];
      PM_LATER_STAGE_GAIN_O  <= later_loaded_r[`F_PM_LATER];
    end
  end

endmodule // rx_config_register_bank

// [rx_cfg_consts.vh]
// constants for the receiver configuration register bank
`ifndef RX_CFG_CONSTS_VH
`define RX_CFG_CONSTS_VH

// ----------------------------------------------------------------
// addresses
// ----------------------------------------------------------------
`define ADDR_FILTER_CHANNEL  6'h0A
`define ADDR_AGC_SQUELCH     6'h0B
`define ADDR_FIRST_GAIN      6'h0C
`define ADDR_LATER_GAIN      6'h0D

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_FILTER_CHANNEL   8'h00
`define RST_AGC_SQUELCH      8'h1A
`define RST_FIRST_GAIN       8'hD8
`define RST_LATER_GAIN       8'h00

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define B_CH_PICK            7
`define B_AMD_MIXER          6
`define F_LOWPASS            5:3
`define F_ZERO_SET           2:0
`define B_LOW_POWER          7
`define B_LF_SPLIT           6
`define B_LF_ON              5
`define B_AGC_EN             4
`define B_AGC_FULL           3
`define B_AGC_RESET_ALG      2
`define B_SQUELCH_AUTO       1
`define B_PMIX_INTERNAL      0
`define F_AM_FIRST           7:5
`define F_PM_FIRST           4:2
`define B_CLIP               1
`define B_PEER_FORCE         0
`define F_AM_LATER           7:4
`define F_PM_LATER           3:0

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SQUELCH_DELAY_NS     18880
`define CLK_PERIOD_NS        10
`define MASK_STEP_CARRIER    64

`endif

// [rx_squelch_timer.v]
// automatic squelch window timer after end of transmit
`timescale 1ns/1ns
module rx_squelch_timer #(
  parameter DELAY_CYC = 1888
) (
  input  wire       clk_i,
  input  wire       rst_n_i,
  input  wire       enable_i,
  input  wire       tx_end_i,
  input  wire       mask_expired_i,
  output reg        squelch_o
);

  reg  [15:0] cnt_r;
  reg         waiting_r;

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r     <= 16'h0000;
      waiting_r <= 1'b0;
      squelch_o <= 1'b0;
    end else if (mask_expired_i || !enable_i) begin
      cnt_r     <= 16'h0000;
      waiting_r <= 1'b0;
      squelch_o <= 1'b0;
    end else if (tx_end_i) begin
      cnt_r     <= 16'h0000;
      waiting_r <= 1'b1;
      squelch_o <= 1'b0;
    end else if (waiting_r) begin
      if (cnt_r == DELAY_CYC[15:0] - 16'h0001) begin
        waiting_r <= 1'b0;
        squelch_o <= 1'b1;
      end else begin
        cnt_r <= cnt_r + 16'h0001;
      end
    end
  end

endmodule // rx_squelch_timer

// [rx_cfg_checker_assertions.sv]
// port checker for the receiver configuration register bank
`timescale 1ns/1ns
module rx_cfg_checker #(
  parameter ADDR_W = 6
) (
  input wire              CLK_I,
  input wire              RST_N_I,
  input wire [ADDR_W-1:0] ADDR_I,
  input wire              WR_EN_I,
  input wire              RD_EN_I,
  input wire [7:0]        WDATA_I,
  input wire [7:0]        RDATA_O,
  input wire              RVALID_O,
  input wire              SET_DEFAULT_I,
  input wire              RESET_RX_GAIN_I,
  input wire              TX_END_I,
  input wire              MASK_EXPIRED_I,
  input wire              SINGLE_ENDED_I,
  input wire              AGC_ENABLE_O,
  input wire              SQUELCH_ACTIVE_O,
  input wire              PM_MIXER_CLOCK_SRC_O,
  input wire [2:0]        AM_FIRST_STAGE_GAIN_O,
  input wire [3:0]        AM_LATER_STAGE_GAIN_O
);
  reg        tx_q_r;
  reg [11:0] since_tx_r;
  // cycles since the transmit-end pin rose
  always @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      tx_q_r     <= 1'b0;
      since_tx_r <= 12'hFFF;
    end else begin
      tx_q_r <= TX_END_I;
      if (TX_END_I && !tx_q_r) since_tx_r <= 12'h000;
      else if (since_tx_r != 12'hFFF) since_tx_r <= since_tx_r + 12'h001;
    end
  end
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  read_valid_pulse_a: assert property (RD_EN_I |=> RVALID_O)
    else $error("no read answer");
  no_stray_valid_a: assert property (!RD_EN_I |=> !RVALID_O)
    else $error("read answer without request");
  unmapped_read_zero_a: assert property (
    RD_EN_I && (ADDR_I < 6'h0A || ADDR_I > 6'h0D) |=> RDATA_O == 8'h00)
    else $error("unmapped read not zero");
  write_read_back_a: assert property (
    WR_EN_I && !SET_DEFAULT_I && ADDR_I >= 6'h0A && ADDR_I <= 6'h0D
    ##1 RD_EN_I && !WR_EN_I && $stable(ADDR_I) |=> RDATA_O == $past(WDATA_I, 2))
    else $error("read back differs from write");
  gain_field_a: assert property (
    WR_EN_I && ADDR_I == 6'h0C && !SET_DEFAULT_I
    |=> ##1 AM_FIRST_STAGE_GAIN_O == ($past(WDATA_I, 2) >> 5))
    else $error("first stage gain output wrong");
  default_restore_a: assert property (SET_DEFAULT_I |=> ##1
    AGC_ENABLE_O && AM_FIRST_STAGE_GAIN_O == 3'h6 && AM_LATER_STAGE_GAIN_O == 4'h0)
    else $error("defaults not restored");
  gain_held_a: assert property (!$stable(AM_LATER_STAGE_GAIN_O)
    |-> $past(RESET_RX_GAIN_I, 2) || $past(SET_DEFAULT_I, 2))
    else $error("later gain changed without load");
  single_forces_a: assert property (SINGLE_ENDED_I [*5] |-> PM_MIXER_CLOCK_SRC_O)
    else $error("mixer clock not internal");
  squelch_delay_a: assert property ($rose(SQUELCH_ACTIVE_O)
    |-> since_tx_r >= 12'h75D && since_tx_r <= 12'h771)
    else $error("squelch start time wrong");
  mask_ends_squelch_a: assert property (
    $rose(MASK_EXPIRED_I) |-> ##[1:8] !SQUELCH_ACTIVE_O)
    else $error("squelch not ended by mask expiry");
  read_c: cover property (RD_EN_I ##1 RVALID_O);
  gain_load_c: cover property (RESET_RX_GAIN_I ##2 AM_LATER_STAGE_GAIN_O != 4'h0);
  squelch_c: cover property ($rose(SQUELCH_ACTIVE_O));
endmodule // rx_cfg_checker

bind rx_config_register_bank rx_cfg_checker #(.ADDR_W(ADDR_W)) chk (
  .CLK_I(CLK_I), .RST_N_I(RST_N_I), .ADDR_I(ADDR_I), .WR_EN_I(WR_EN_I),
  .RD_EN_I(RD_EN_I), .WDATA_I(WDATA_I), .RDATA_O(RDATA_O), .RVALID_O(RVALID_O),
  .SET_DEFAULT_I(SET_DEFAULT_I), .RESET_RX_GAIN_I(RESET_RX_GAIN_I),
  .TX_END_I(TX_END_I), .MASK_EXPIRED_I(MASK_EXPIRED_I),
  .SINGLE_ENDED_I(SINGLE_ENDED_I), .AGC_ENABLE_O(AGC_ENABLE_O),
  .SQUELCH_ACTIVE_O(SQUELCH_ACTIVE_O), .PM_MIXER_CLOCK_SRC_O(PM_MIXER_CLOCK_SRC_O),
  .AM_FIRST_STAGE_GAIN_O(AM_FIRST_STAGE_GAIN_O),
  .AM_LATER_STAGE_GAIN_O(AM_LATER_STAGE_GAIN_O));

// [test_rx_config_register_bank.sv]
// self-checking bench for the receiver configuration register bank
`timescale 1ns/1ns
`include "rx_cfg_consts.vh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin mismatches++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module test_rx_config_register_bank;
  logic       clk = 1'b0, rst_n = 1'b0, wr_en = 1'b0, rd_en = 1'b0, set_def = 1'b0;
  logic       gain_ld = 1'b0, tx_end = 1'b0, mask_exp = 1'b0, single = 1'b0;
  logic [5:0] addr = 6'h00;
  logic [7:0] wdata = 8'h00;
  wire  [7:0] rdata;
  wire        rvalid, ch_pick, amd_mix, low_pwr, lf_split, lf_on, agc_en, agc_full;
  wire        agc_alg, squelch, pmix, clip, peer;
  wire  [2:0] lp, zs, am1, pm1;
  wire  [3:0] am2, pm2;
  int         mismatches = 0, samples_checked = 0, seed = 81;
  logic [7:0] exp_q[$];
  logic [7:0] exp_rd;
  logic [7:0] d[4];
  logic [7:0] dflt[4] = '{`RST_FILTER_CHANNEL, `RST_AGC_SQUELCH, `RST_FIRST_GAIN,
                          `RST_LATER_GAIN};
  always #5 clk = ~clk;
  rx_config_register_bank dut (.CLK_I(clk), .RST_N_I(rst_n), .ADDR_I(addr),
    .WR_EN_I(wr_en), .RD_EN_I(rd_en), .WDATA_I(wdata), .RDATA_O(rdata),
    .RVALID_O(rvalid), .SET_DEFAULT_I(set_def), .RESET_RX_GAIN_I(gain_ld),
    .TX_END_I(tx_end), .MASK_EXPIRED_I(mask_exp), .SINGLE_ENDED_I(single),
    .RX_CHANNEL_PICK_O(ch_pick), .AM_DEMOD_MIXER_O(amd_mix), .LOWPASS_CODE_O(lp),
    .ZERO_SET_O(zs), .RECEIVER_LOW_POWER_O(low_pwr), .LOWFREQ_SPLIT_ROUTE_O(lf_split),
    .LOWFREQ_INPUT_ON_O(lf_on), .AGC_ENABLE_O(agc_en), .AGC_FULL_PERIOD_O(agc_full),
    .AGC_RESET_ALG_O(agc_alg), .SQUELCH_ACTIVE_O(squelch),
    .PM_MIXER_CLOCK_SRC_O(pmix), .AM_FIRST_STAGE_GAIN_O(am1),
    .PM_FIRST_STAGE_GAIN_O(pm1), .STAGE_CLIP_O(clip), .PEER_MODE_GAIN_FORCE_O(peer),
    .AM_LATER_STAGE_GAIN_O(am2), .PM_LATER_STAGE_GAIN_O(pm2));
  // ----------------------------------------------------------------
  // host cycles
  // ----------------------------------------------------------------
  task wr(input logic [5:0] a, input logic [7:0] v);
    addr = a; wdata = v; wr_en = 1'b1; rd_en = 1'b0;
    @(posedge clk); #1;
  endtask
  task rd(input logic [5:0] a, input logic [7:0] e);
    addr = a; rd_en = 1'b1; wr_en = 1'b0;
    exp_q.push_back(e);
    @(posedge clk); #1;
  endtask
  task idle(input int n);
    wr_en = 1'b0; rd_en = 1'b0;
    repeat (n) begin @(posedge clk); #1; end
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // read answer monitor
  // ----------------------------------------------------------------
  always @(negedge clk) begin
    if (rvalid === 1'b1) begin
      if (exp_q.size() == 0) `CHK(rvalid, 1'b0)
      else begin
        // take the note off once; the compare macro reads its arguments twice
        exp_rd = exp_q.pop_front();
        `CHK(rdata, exp_rd)
      end
    end
  end
  initial begin
    #200000; mismatches++; end_sim;
  end
  initial begin
    repeat (20) @(posedge clk); #1; rst_n = 1'b1;
    for (int i = 0; i < 4; i++) rd(6'h0A + i, dflt[i]);
    rd(6'h09, 8'h00); rd(6'h0E, 8'h00);
    for (int i = 0; i < 4; i++) begin
      d[i] = $random(seed);
      wr(6'h0A + i, d[i]); rd(6'h0A + i, d[i]);
    end
    idle(2);
    `CHK({ch_pick, amd_mix, lp, zs}, d[0])
    `CHK({low_pwr, lf_split, lf_on, agc_en, agc_full, agc_alg, pmix}, {d[1][7:2], d[1][0]})
    `CHK({am1, pm1, clip, peer}, d[2])
    `CHK({am2, pm2}, 8'h00)
    gain_ld = 1'b1; idle(1); gain_ld = 1'b0; idle(2);
    `CHK({am2, pm2}, d[3])
    wr(6'h0B, d[1] & 8'hFE); single = 1'b1; idle(5);
    `CHK(pmix, 1'b1)
    single = 1'b0; gain_ld = 1'b1; wr(6'h0D, 8'hFB); gain_ld = 1'b0; idle(2);
    `CHK({am2, pm2}, d[3])
    gain_ld = 1'b1; rd(6'h0D, 8'hFB); gain_ld = 1'b0; idle(2);
    `CHK({am2, pm2}, 8'hFB)
    set_def = 1'b1; wr(6'h0A, 8'hFF); set_def = 1'b0;
    for (int i = 0; i < 4; i++) rd(6'h0A + i, dflt[i]);
    idle(2);
    `CHK({am2, pm2, pmix}, 9'h000)
    tx_end = 1'b1; idle(1880);
    `CHK(squelch, 1'b0)
    idle(25);
    `CHK(squelch, 1'b1)
    mask_exp = 1'b1; idle(8);
    `CHK(squelch, 1'b0)
    tx_end = 1'b0; mask_exp = 1'b0; wr(6'h0B, 8'h18); tx_end = 1'b1; idle(1910);
    `CHK(squelch, 1'b0)
    end_sim;
  end
endmodule // test_rx_config_register_bank
